// ===== rtl/lcd_loop_code.sv
// Functional notes
// - Detect select 00 turns detection off and 01 watches received data for the loop-up code.
// - Detect select 10 watches received data for the loop-down code.
// - Detect select 11 watches for loop-up and enters remote loop-back once it is recognised.
// - Repeating 00001 is the loop-up code; the status bit sets once it lasts beyond five seconds.
// - Repeating 001 is the loop-down code; the status bit sets once it lasts beyond five seconds.
// - A status bit that becomes set with its interrupt enable on raises an interrupt.
// - Entering automatic mode clears the status bit and starts watching for loop-up.
// - In automatic mode loop-up lasting beyond five seconds sets status and starts remote loop-back.
// - Once remote loop-back is active in automatic mode, watching switches to the loop-down code.
// - In automatic mode the status bit stays set after the loop-up code stops arriving.
// - Automatic remote loop-back ends only on loop-down detection or on leaving the mode.
// - With test select 100 a zero-to-one write of inject corrupts exactly one QRSS bit.
// - The inject bit is sampled on rising transmit clock edges to find its rising change.
// - With the change interrupt enabled, both start and end of detection raise it.
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module lcd_loop_code
   import lcd_pkg::*;
#(
   parameter int PERSIST_BITS = LCD_PERSIST_BITS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic receive_line_clock,
   input wire logic receive_line_data,
   input wire logic transmit_line_clock,
   input wire logic tx_pattern_bit,
   output logic tx_line_data,
   output logic remote_loopback,
   output logic irq
);
   initial begin
      if (PERSIST_BITS < 1 || PERSIST_BITS >= (1 << LCD_CNT_W)) begin
         $error("lcd_loop_code: PERSIST_BITS out of range");
      end
   end

   typedef struct packed {
      logic rx_clk_s1;
      logic rx_clk_s2;
      logic rx_clk_p;
      logic rx_dat_s1;
      logic rx_dat_s2;
      logic tx_clk_s1;
      logic tx_clk_s2;
      logic tx_clk_p;
      logic [1:0] sel;
      logic inject;
      logic [2:0] test_sel;
      logic irq_en;
      logic status;
      logic irq_pend;
      logic loopback;
      lcd_auto_t ast;
      logic restart;
      logic inj_prev;
      logic armed;
      logic tx_data;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic readyout;
      logic resp;
      logic irq;
   } lcd_state_t;

   lcd_state_t q, d;
   logic rx_valid;
   logic tx_edge;
   logic det;
   logic det_ok;
   logic watch_down;
   logic [31:0] rd_word;

   assign rx_valid = q.rx_clk_s2 && !q.rx_clk_p;
   assign tx_edge = q.tx_clk_s2 && !q.tx_clk_p;
   assign det_ok = det && !q.restart;
   // Loop-down is watched in select 10 and after automatic loop-back starts
   assign watch_down = (q.sel == LCD_SEL_DOWN)
      || (q.sel == LCD_SEL_AUTO && q.ast == LCD_AU_LOOPED);

   lcd_persist #(
      .PERSIST_BITS(PERSIST_BITS)
   ) u_persist (
      .clk(clk),
      .rst_n(rst_n),
      .bit_valid(rx_valid),
      .bit_in(q.rx_dat_s2),
      .watch_down(watch_down),
      .restart(q.restart),
      .detected(det)
   );

   always_comb begin
      d = q;
      rd_word = '0;
      // Pin synchronisers
      d.rx_clk_s1 = receive_line_clock;
      d.rx_clk_s2 = q.rx_clk_s1;
      d.rx_clk_p = q.rx_clk_s2;
      d.rx_dat_s1 = receive_line_data;
      d.rx_dat_s2 = q.rx_dat_s1;
      d.tx_clk_s1 = transmit_line_clock;
      d.tx_clk_s2 = q.tx_clk_s1;
      d.tx_clk_p = q.tx_clk_s2;
      d.restart = 1'b0;
      d.readyout = 1'b1;
      d.resp = 1'b0;

      // Bus write data phase
      if (q.wr_pend) begin
         if (q.wr_addr == LCD_OFS_CTRL3) begin
            d.sel = hwdata[LCD_SEL_LSB+1:LCD_SEL_LSB];
            d.inject = hwdata[LCD_INJ_BIT];
         end else if (q.wr_addr == LCD_OFS_TEST) begin
            d.test_sel = hwdata[2:0];
         end else if (q.wr_addr == LCD_OFS_IRQ_EN) begin
            d.irq_en = hwdata[LCD_IRQ_EN_BIT];
         end else if (q.wr_addr == LCD_OFS_STATUS) begin
            if (hwdata[LCD_PEND_BIT]) begin
               d.irq_pend = 1'b0;
            end
         end
      end

      // Detection behaviour
      if (d.sel != q.sel) begin
         d.restart = 1'b1;
         d.status = 1'b0;
         d.loopback = 1'b0;
         d.ast = (d.sel == LCD_SEL_AUTO) ? LCD_AU_WAIT_UP : LCD_AU_OFF;
      end else begin
         unique case (q.sel)
            LCD_SEL_OFF: begin
               d.status = 1'b0;
               d.loopback = 1'b0;
            end
            LCD_SEL_UP: begin
               d.status = det_ok;
            end
            LCD_SEL_DOWN: begin
               d.status = det_ok;
            end
            LCD_SEL_AUTO: begin
               unique case (q.ast)
                  LCD_AU_WAIT_UP: begin
                     if (det_ok) begin
                        d.status = 1'b1;
                        d.loopback = 1'b1;
                        d.ast = LCD_AU_LOOPED;
                        d.restart = 1'b1;
                     end
                  end
                  LCD_AU_LOOPED: begin
                     // Status holds while loop-up is gone; loop-down ends loop-back
                     if (det_ok) begin
                        d.loopback = 1'b0;
                        d.status = 1'b0;
                        d.ast = LCD_AU_WAIT_UP;
                        d.restart = 1'b1;
                     end
                  end
                  LCD_AU_OFF: begin
                     d.ast = LCD_AU_WAIT_UP;
                     d.restart = 1'b1;
                  end
               endcase
            end
         endcase
      end

      // Change of detection raises the interrupt; set wins over clear
      if (d.status != q.status && q.irq_en) begin
         d.irq_pend = 1'b1;
      end
      d.irq = d.irq_pend;

      // Transmit side, stepped on each transmit clock rise
      if (tx_edge) begin
         d.inj_prev = q.inject;
         d.tx_data = tx_pattern_bit ^ q.armed;
         d.armed = q.inject && !q.inj_prev && (q.test_sel == LCD_TEST_QRSS);
      end

      // Read mux sees this cycle's register updates
      if (haddr[7:0] == LCD_OFS_CTRL3) begin
         rd_word[LCD_SEL_LSB+1:LCD_SEL_LSB] = d.sel;
         rd_word[LCD_INJ_BIT] = d.inject;
      end else if (haddr[7:0] == LCD_OFS_STATUS) begin
         rd_word[LCD_STATUS_BIT] = d.status;
         rd_word[LCD_PEND_BIT] = d.irq_pend;
         rd_word[LCD_LOOPBACK_BIT] = d.loopback;
      end else if (haddr[7:0] == LCD_OFS_IRQ_EN) begin
         rd_word[LCD_IRQ_EN_BIT] = d.irq_en;
      end else if (haddr[7:0] == LCD_OFS_TEST) begin
         rd_word[2:0] = d.test_sel;
      end

      // Bus address phase
      d.wr_pend = 1'b0;
      d.rdata = '0;
      if (hsel && htrans[1] && hready) begin
         d.wr_pend = hwrite && (haddr[31:8] == '0);
         d.wr_addr = haddr[7:0];
         if (!hwrite && haddr[31:8] == '0) begin
            d.rdata = rd_word;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.sel <= LCD_SEL_RST;
         q.test_sel <= LCD_TEST_RST;
         q.ast <= LCD_AU_OFF;
         q.readyout <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign hreadyout = q.readyout;
   assign hresp = q.resp;
   assign hrdata = q.rdata;
   assign tx_line_data = q.tx_data;
   assign remote_loopback = q.loopback;
   assign irq = q.irq;

   AST_SEL_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      q.sel == LCD_SEL_OFF && $stable(q.sel) |=> !q.status && !remote_loopback)
      else $error("Status or loop-back active with detection off");

   AST_DOWN_WATCH: assert property (@(posedge clk) disable iff (!rst_n)
      q.sel == LCD_SEL_DOWN |-> watch_down)
      else $error("Select 10 does not watch the loop-down code");

   AST_AUTO_LB: assert property (@(posedge clk) disable iff (!rst_n)
      q.sel == LCD_SEL_AUTO && q.ast == LCD_AU_LOOPED |-> remote_loopback && watch_down)
      else $error("Automatic loop-back state without loop-back output");

   AST_UP_STATUS: assert property (@(posedge clk) disable iff (!rst_n)
      q.sel == LCD_SEL_UP && $stable(q.sel) && det_ok && !q.wr_pend |=> q.status)
      else $error("Loop-up detection did not set status");

   AST_DOWN_STATUS: assert property (@(posedge clk) disable iff (!rst_n)
      q.sel == LCD_SEL_DOWN && $stable(q.sel) && det_ok && !q.wr_pend |=> q.status)
      else $error("Loop-down detection did not set status");

   AST_IRQ_CHANGE: assert property (@(posedge clk) disable iff (!rst_n)
      $past(q.irq_en) && $rose(q.status) |-> irq)
      else $error("Status set with enable on raised no interrupt");

   AST_IRQ_DROP: assert property (@(posedge clk) disable iff (!rst_n)
      $past(q.irq_en) && $fell(q.status) |-> irq)
      else $error("Status clear with enable on raised no interrupt");

   AST_IRQ_CAUSE: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(irq) |-> $changed(q.status) && $past(q.irq_en))
      else $error("Interrupt raised without an enabled status change");

   AST_UP_WATCH: assert property (@(posedge clk) disable iff (!rst_n)
      q.sel == LCD_SEL_UP || (q.sel == LCD_SEL_AUTO && q.ast != LCD_AU_LOOPED)
      |-> !watch_down)
      else $error("Loop-up watch selected but loop-down watched");

   AST_LB_AUTO_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
      remote_loopback |-> q.sel == LCD_SEL_AUTO)
      else $error("Loop-back active outside automatic mode");

   AST_WAIT_NO_LB: assert property (@(posedge clk) disable iff (!rst_n)
      q.sel == LCD_SEL_AUTO && q.ast == LCD_AU_WAIT_UP |-> !remote_loopback)
      else $error("Loop-back active before loop-up was recognised");

   AST_AUTO_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
      q.sel == LCD_SEL_AUTO && q.ast == LCD_AU_LOOPED && det_ok && !q.wr_pend
      |=> !remote_loopback && q.ast == LCD_AU_WAIT_UP)
      else $error("Loop-down in automatic mode did not release loop-back");

   AST_SEL_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(q.sel) |-> q.restart)
      else $error("Mode change did not restart the persistence count");

   AST_QRSS_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(q.armed) |-> $past(q.test_sel) == LCD_TEST_QRSS)
      else $error("Error armed without the QRSS test selection");

   AST_INJ_REFUSED: assert property (@(posedge clk) disable iff (!rst_n)
      tx_edge && q.test_sel != LCD_TEST_QRSS |=> !q.armed)
      else $error("Error armed while another test pattern is selected");

   AST_TX_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !tx_edge |=> $stable(tx_line_data))
      else $error("Transmitted bit changed between transmit clock rises");

   AST_AUTO_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(q.sel) && q.sel == LCD_SEL_AUTO |-> !q.status && q.ast == LCD_AU_WAIT_UP)
      else $error("Entry to automatic mode did not clear status");

   AST_AUTO_START: assert property (@(posedge clk) disable iff (!rst_n)
      q.sel == LCD_SEL_AUTO && q.ast == LCD_AU_WAIT_UP && det_ok && !q.wr_pend
      |=> q.status && remote_loopback ##1 q.restart == 1'b0)
      else $error("Loop-up in automatic mode did not start loop-back");

   AST_AUTO_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      q.sel == LCD_SEL_AUTO && q.ast == LCD_AU_LOOPED && !det_ok && !q.wr_pend
      |=> q.status)
      else $error("Status dropped while automatic loop-back held");

   AST_LB_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(remote_loopback) |-> $past(det_ok) || $changed(q.sel))
      else $error("Loop-back released without cause");

   AST_SINGLE_ERR: assert property (@(posedge clk) disable iff (!rst_n)
      tx_edge |=> tx_line_data == ($past(tx_pattern_bit) ^ $past(q.armed)))
      else $error("Transmitted bit does not match pattern and error arm");

   AST_TX_SAMPLE: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(q.armed) |-> $past(tx_edge) && $past(q.inject) && !$past(q.inj_prev))
      else $error("Error armed outside a transmit clock rise");

   AST_ONE_BIT: assert property (@(posedge clk) disable iff (!rst_n)
      q.armed && tx_edge |=> !q.armed)
      else $error("Error stayed armed after one transmitted bit");

   COV_UP_DET: cover property (@(posedge clk) disable iff (!rst_n)
      q.sel == LCD_SEL_UP && $rose(q.status));
   COV_AUTO_LOOP: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(remote_loopback) ##[1:1000] $fell(remote_loopback));
   COV_ERR_INJ: cover property (@(posedge clk) disable iff (!rst_n)
      q.armed && tx_edge);
   COV_IRQ: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
   COV_DOWN_DET: cover property (@(posedge clk) disable iff (!rst_n)
      q.sel == LCD_SEL_DOWN && $rose(q.status));
endmodule
`default_nettype wire

// ===== rtl/lcd_persist.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_persist
   import lcd_pkg::*;
#(
   parameter int PERSIST_BITS = LCD_PERSIST_BITS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic bit_valid,
   input wire logic bit_in,
   input wire logic watch_down,
   input wire logic restart,
   output logic detected
);
   initial begin
      if (PERSIST_BITS < 1 || PERSIST_BITS >= (1 << LCD_CNT_W)) begin
         $error("lcd_persist: PERSIST_BITS out of range");
      end
   end

   localparam logic [LCD_CNT_W-1:0] LIMIT = LCD_CNT_W'(PERSIST_BITS);

   typedef struct packed {
      logic [LCD_UP_PERIOD-1:0] hist;
      logic [LCD_CNT_W-1:0] cnt;
      logic det;
   } lcd_persist_st_t;

   lcd_persist_st_t q, d;
   logic in_pattern;

   always_comb begin
      d = q;
      in_pattern = 1'b0;
      if (watch_down) begin
         in_pattern = (bit_in == q.hist[LCD_DOWN_PERIOD-1])
            && ($countones({q.hist[LCD_DOWN_PERIOD-2:0], bit_in}) == 1);
      end else begin
         in_pattern = (bit_in == q.hist[LCD_UP_PERIOD-1])
            && ($countones({q.hist[LCD_UP_PERIOD-2:0], bit_in}) == 1);
      end
      if (restart) begin
         d.hist = '0;
         d.cnt = '0;
      end else if (bit_valid) begin
         d.hist = {q.hist[LCD_UP_PERIOD-2:0], bit_in};
         // Any break of the repeating pattern restarts the count
         if (!in_pattern) begin
            d.cnt = '0;
         end else if (q.cnt != LIMIT) begin
            d.cnt = q.cnt + LCD_CNT_W'(1);
         end
      end
      d.det = (d.cnt == LIMIT);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign detected = q.det;

   AST_PERSIST_BREAK: assert property (@(posedge clk) disable iff (!rst_n)
      bit_valid && !restart && !in_pattern |=> q.cnt == '0 && !detected)
      else $error("Pattern break did not restart the persistence count");
endmodule
`default_nettype wire

// ===== rtl/lcd_pkg.sv
package lcd_pkg;
   // Register byte offsets
   localparam logic [7:0] LCD_OFS_CTRL3 = 8'h00;
   localparam logic [7:0] LCD_OFS_STATUS = 8'h04;
   localparam logic [7:0] LCD_OFS_IRQ_EN = 8'h08;
   localparam logic [7:0] LCD_OFS_TEST = 8'h0C;
   // Field positions
   localparam int LCD_SEL_LSB = 6;
   localparam int LCD_INJ_BIT = 1;
   localparam int LCD_LOOPBACK_BIT = 0;
   localparam int LCD_STATUS_BIT = 3;
   localparam int LCD_PEND_BIT = 4;
   localparam int LCD_IRQ_EN_BIT = 3;
   // Reset values
   localparam logic [1:0] LCD_SEL_RST = 2'h0;
   localparam logic [2:0] LCD_TEST_RST = 3'h0;
   // Detect and test select codes
   localparam logic [1:0] LCD_SEL_OFF = 2'b00;
   localparam logic [1:0] LCD_SEL_UP = 2'b01;
   localparam logic [1:0] LCD_SEL_DOWN = 2'b10;
   localparam logic [1:0] LCD_SEL_AUTO = 2'b11;
   localparam logic [2:0] LCD_TEST_QRSS = 3'b100;
   // Loop code periods in line bits
   localparam int LCD_UP_PERIOD = 5;
   localparam int LCD_DOWN_PERIOD = 3;
   // Persistence, counted in received line bits
   localparam int LCD_PERSIST_S = 5;
   localparam int LCD_LINE_RATE_HZ = 1544000;
   localparam int LCD_PERSIST_BITS = LCD_PERSIST_S * LCD_LINE_RATE_HZ;
   localparam int LCD_CNT_W = 24;

   typedef enum logic [1:0] {
      LCD_AU_OFF,
      LCD_AU_WAIT_UP,
      LCD_AU_LOOPED
   } lcd_auto_t;
endpackage

// ===== testbench/lcd_remote_end.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_remote_end (
   input wire logic clk,
   input wire logic [1:0] code_sel,
   output logic line_clk,
   output logic line_data
);
   int ph;
   int n;
   initial begin
      line_clk = 1'b0;
      line_data = 1'b0;
      ph = 0;
      forever begin
         @(posedge clk);
         line_clk <= 1'b0;
         if (code_sel != 2'd0) begin
            // Period 5 sends 00001, period 3 sends 001, 3 sends all ones
            n = (code_sel == 2'd1) ? 5 : 3;
            line_data <= (code_sel == 2'd3) ? 1'b1 : (ph % n == n - 1);
            ph++;
            repeat (4) @(posedge clk);
            line_clk <= 1'b1;
            repeat (3) @(posedge clk);
         end else begin
            // Idle: clock parked, data shows no stale bit
            line_data <= ~line_data;
         end
      end
   end
endmodule
`default_nettype wire

// ===== testbench/loop_code_detect_error_insert_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
   $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module loop_code_detect_error_insert_test;
   import lcd_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [31:0] haddr = '0;
   logic [31:0] hwdata = '0;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic rx_clk;
   logic rx_dat;
   logic tx_clk = 1'b0;
   logic tx_pat = 1'b0;
   logic tx_line_data;
   logic remote_loopback;
   logic irq;
   logic tx_prev = 1'b0;
   logic [1:0] code = 2'd0;
   logic [31:0] v;
   int errors = 0;
   int n_compared = 0;
   int rises = 0;
   int flips = 0;
   assign hready = hreadyout;
   always #2 clk = ~clk;
   always begin
      repeat (4) @(posedge clk);
      tx_clk <= ~tx_clk;
   end
   // Count error bursts and error cycles against the steady pattern bit
   always @(posedge clk) begin
      tx_prev <= tx_line_data ^ tx_pat;
      if ((tx_line_data ^ tx_pat) === 1'b1) begin
         flips++;
         if (tx_prev === 1'b0) rises++;
      end
   end
   lcd_loop_code #(.PERSIST_BITS(20)) uut (
      .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .receive_line_clock(rx_clk), .receive_line_data(rx_dat),
      .transmit_line_clock(tx_clk), .tx_pattern_bit(tx_pat),
      .tx_line_data(tx_line_data), .remote_loopback(remote_loopback), .irq(irq));
   lcd_remote_end far (.clk(clk), .code_sel(code), .line_clk(rx_clk), .line_data(rx_dat));
   task automatic final_report();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic hold_ready();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hready !== 1'b1 && k < 64);
      if (k >= 64) begin
         errors++;
         final_report();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= 32'(a);
      hold_ready();
      htrans <= 2'b00;
      hwdata <= d;
      hold_ready();
      v = hrdata;
   endtask
   task automatic wait_bit(input int pos, input logic val);
      int k;
      k = 0;
      do begin
         bus(1'b0, LCD_OFS_STATUS, '0);
         k++;
      end while (v[pos] !== val && k < 400);
      if (k >= 400) begin
         errors++;
         final_report();
      end
   endtask
   task automatic sc_reset();
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, 8'(4 * i), '0);
         `CHK(v, 32'h0000_0000)
         `CHK({hresp, hreadyout}, 2'b01)
      end
   endtask
   task automatic sc_off();
      code <= 2'd1;
      repeat (600) @(posedge clk);
      bus(1'b0, LCD_OFS_STATUS, '0);
      `CHK(v[3], 1'b0)
   endtask
   task automatic sc_up();
      bus(1'b1, LCD_OFS_IRQ_EN, 32'h0000_0008);
      bus(1'b1, LCD_OFS_CTRL3, 32'h0000_0040);
      wait_bit(3, 1'b1);
      `CHK(v[3], 1'b1)
      @(posedge clk);
      `CHK(irq, 1'b1)
      bus(1'b1, LCD_OFS_STATUS, 32'h0000_0010);
      @(posedge clk);
      `CHK(irq, 1'b0)
      code <= 2'd3;
      wait_bit(3, 1'b0);
      @(posedge clk);
      `CHK(irq, 1'b1)
   endtask
   task automatic sc_down();
      bus(1'b1, LCD_OFS_CTRL3, 32'h0000_0080);
      code <= 2'd2;
      wait_bit(3, 1'b1);
      `CHK(v[3], 1'b1)
      code <= 2'd1;
      wait_bit(3, 1'b0);
      `CHK(v[3], 1'b0)
      code <= 2'd2;
      wait_bit(3, 1'b1);
   endtask
   task automatic sc_auto();
      bus(1'b1, LCD_OFS_CTRL3, 32'h0000_00C0);
      bus(1'b0, LCD_OFS_STATUS, '0);
      `CHK(v[3], 1'b0)
      code <= 2'd1;
      wait_bit(0, 1'b1);
      `CHK(v[3], 1'b1)
      `CHK(remote_loopback, 1'b1)
      code <= 2'd3;
      repeat (400) @(posedge clk);
      bus(1'b0, LCD_OFS_STATUS, '0);
      `CHK(v[3], 1'b1)
      `CHK(remote_loopback, 1'b1)
      code <= 2'd2;
      wait_bit(0, 1'b0);
      `CHK(remote_loopback, 1'b0)
      code <= 2'd1;
      wait_bit(0, 1'b1);
      bus(1'b1, LCD_OFS_CTRL3, 32'h0000_0040);
      repeat (2) @(posedge clk);
      `CHK(remote_loopback, 1'b0)
   endtask
   task automatic sc_inject(input logic [31:0] sel, input logic pat, input int want);
      tx_pat <= pat;
      bus(1'b1, LCD_OFS_TEST, sel);
      bus(1'b1, LCD_OFS_CTRL3, 32'h0000_0000);
      repeat (40) @(posedge clk);
      rises = 0;
      flips = 0;
      bus(1'b1, LCD_OFS_CTRL3, 32'h0000_0002);
      repeat (400) @(posedge clk);
      `CHK(rises, want)
      `CHK(flips, 8 * want)
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      sc_reset();
      sc_off();
      sc_up();
      sc_down();
      sc_auto();
      sc_inject(32'h0000_0004, 1'b1, 1);
      sc_inject(32'h0000_0000, 1'b0, 0);
      final_report();
   end
endmodule
`default_nettype wire
